// >>> bench/clock_startup_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================
// Start-up control checker
module clock_startup_checker
(
	// Clock and reset
	input wire logic                           core_clk,
	input wire logic                           sys_rst,
	// Fuse and requests
	input wire logic                           clock_divide_by_eight_fuse,
	input wire logic                           external_reset_active,
	input wire logic                           wake_request,
	// Status
	input wire clk_startup_pkg::clock_source_t selected_source,
	input wire logic                           internal_reset,
	input wire logic                           system_clock_enable,
	input wire logic                           fuse_reserved,
	input wire logic                           waking
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_rst_hold; $fell(sys_rst) |-> internal_reset; endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("reset not held");
	property p_ext; external_reset_active |=> internal_reset; endproperty
	a_ext: assert property (p_ext) else $error("reset source ignored");
	property p_div8;
		!clock_divide_by_eight_fuse && system_clock_enable |=> !system_clock_enable [*7] ##1 system_clock_enable;
	endproperty
	a_div8: assert property (p_div8) else $error("enable not every 8th");
	property p_div1;
		clock_divide_by_eight_fuse && system_clock_enable && !internal_reset |=> system_clock_enable || internal_reset;
	endproperty
	a_div1: assert property (p_div1) else $error("enable gap undivided");
	property p_reserved; fuse_reserved |-> internal_reset && !waking; endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code ran");
	property p_wake; wake_request && !internal_reset |-> ##[1:2] internal_reset; endproperty
	a_wake: assert property (p_wake) else $error("wake ignored");
	property p_waking; waking |-> internal_reset; endproperty
	a_waking: assert property (p_waking) else $error("waking out of reset");
	property p_min_hold; $rose(internal_reset) |-> internal_reset [*6]; endproperty
	a_min_hold: assert property (p_min_hold) else $error("reset too short");
	property p_run_src; !internal_reset |-> selected_source != clk_startup_pkg::SRC_NONE; endproperty
	a_run_src: assert property (p_run_src) else $error("running without source");
endmodule // clock_startup_checker
`default_nettype wire

// >>> bench/osc_source_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================
// Oscillator and watchdog ticks; slow halves both tick rates
module osc_source_model
(
	input wire logic  core_clk,
	input wire logic  slow,
	output var logic  osc_tick = 1'b0,
	output var logic  wdt_tick = 1'b0
);
	logic ph = 1'b0;
	// Plain always: the declaration initialisers keep ph from staying unknown
	always @(posedge core_clk)
	begin
		ph <= ~ph;
		osc_tick <= !slow || ph;
		wdt_tick <= !slow || ph;
	end
endmodule // osc_source_model
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] cs = 4'h2;
	logic [1:0] sut = 2'h2;
	logic div = 1'b0;
	logic ext = 1'b1;
	logic wake = 1'b0;
	logic slow = 1'b0;
	logic wdt, osc, ir, en, rsv, wk;
	clk_startup_pkg::clock_source_t src;
	int err_count = 0;
	int checks_done = 0;
	always #20 core_clk = ~core_clk;
	clock_source_startup_control i_clock_source_startup_control (.core_clk(core_clk), .sys_rst(sys_rst),
		.clock_source_select(cs), .startup_time_select(sut), .clock_divide_by_eight_fuse(div),
		.external_reset_active(ext), .wake_request(wake), .watchdog_tick(wdt), .oscillator_tick(osc),
		.selected_source(src), .internal_reset(ir), .system_clock_enable(en), .fuse_reserved(rsv), .waking(wk));
	osc_source_model i_osc_source_model (.core_clk(core_clk), .slow(slow), .osc_tick(osc), .wdt_tick(wdt));
	// ==========================
	// Helpers
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic print_verdict;
		$display("errors=%0d checks=%0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rng(input int n, input int lo, input int hi);
		chk(n >= lo && n <= hi ? lo : n, lo);
	endtask
	// Bounded: a stuck reset ends the run
	task automatic wait_run(output int n);
		n = 0;
		while (ir !== 1'b0)
		begin
			if (n == 30000)
			begin
				err_count++;
				print_verdict();
			end
			step(1);
			n++;
		end
	endtask
	// Fuses only change while the block is held in reset
	task automatic boot(input logic [3:0] c, input logic [1:0] s, input logic d);
		sys_rst = 1'b1;
		ext = 1'b1;
		cs = c;
		sut = s;
		div = d;
		step(2);
		chk(32'(src), 32'(clk_startup_pkg::SRC_RC_CALIBRATED));
		sys_rst = 1'b0;
		step(1);
		ext = 1'b0;
	endtask
	// ==========================
	// Scenarios
	task automatic decode;
		clk_startup_pkg::clock_source_t e;
		for (int c = 0; c < 16; c++)
		begin
			boot(4'(c), 2'h0, 1'b1);
			step(3);
			e = c[3] ? clk_startup_pkg::SRC_LOW_POWER_XTAL : c[3:1] == 3 ? clk_startup_pkg::SRC_FULL_SWING_XTAL
				: c[3:1] == 2 ? clk_startup_pkg::SRC_LOW_FREQ_XTAL : c == 3 ? clk_startup_pkg::SRC_RC_128K
				: c == 2 ? clk_startup_pkg::SRC_RC_CALIBRATED : clk_startup_pkg::SRC_EXTERNAL;
			if (c != 1)
				chk(32'(src), 32'(e));
			chk(rsv, c == 1);
		end
		boot(4'h4, 2'h3, 1'b1);
		step(3);
		chk(rsv, 1);
	endtask
	task automatic timing(input logic [3:0] c, input logic [1:0] s, input logic d, input int e);
		int n;
		int k;
		boot(c, s, d);
		wait_run(n);
		rng(n, e, e + 8);
		// Undivided, the first enable leaves one cycle after the run starts; divided by eight, eight cycles after
		step(1);
		k = 0;
		repeat (64)
		begin
			k += (en === 1'b1);
			step(1);
		end
		chk(k, d ? 64 : 8);
	endtask
	task automatic wake_case;
		int n;
		timing(4'h8, 2'h0, 1'b1, 784);
		slow = 1'b1;
		wake = 1'b1;
		step(1);
		wake = 1'b0;
		chk(wk, 1);
		wait_run(n);
		rng(n, 510, 530);
		slow = 1'b0;
	endtask
	task automatic restart;
		int n;
		boot(4'h2, 2'h1, 1'b1);
		step(300);
		ext = 1'b1;
		step(2);
		chk(ir, 1);
		ext = 1'b0;
		wait_run(n);
		rng(n, 532, 540);
	endtask
	// Half-rate ticks: the time-out must follow watchdog ticks, not core cycles
	task automatic slow_ticks;
		int n;
		slow = 1'b1;
		boot(4'h2, 2'h1, 1'b1);
		wait_run(n);
		rng(n, 1064, 1072);
		slow = 1'b0;
	endtask
	initial
	begin
		decode();
		timing(4'h2, 2'h0, 1'b1, 20);
		timing(4'h2, 2'h1, 1'b1, 532);
		timing(4'h2, 2'h2, 1'b0, 8212);
		timing(4'h8, 2'h1, 1'b1, 8464);
		timing(4'hA, 2'h2, 1'b1, 1038);
		timing(4'h8, 2'h3, 1'b1, 1550);
		timing(4'hF, 2'h1, 1'b1, 16398);
		timing(4'h7, 2'h2, 1'b1, 16910);
		timing(4'h9, 2'h3, 1'b1, 24590);
		wake_case();
		restart();
		slow_ticks();
		print_verdict();
	end
endmodule // tb_top
bind clock_source_startup_control clock_startup_checker i_clock_startup_checker (.core_clk(core_clk),
	.sys_rst(sys_rst), .clock_divide_by_eight_fuse(clock_divide_by_eight_fuse),
	.external_reset_active(external_reset_active), .wake_request(wake_request), .selected_source(selected_source),
	.internal_reset(internal_reset), .system_clock_enable(system_clock_enable), .fuse_reserved(fuse_reserved),
	.waking(waking));
`default_nettype wire

// >>> hw/clock_source_startup_control.sv
// Behaviour
// R1 - Codes 1111 to 1000 select low-power crystal
// R2 - Codes 0111, 0110 select full-swing crystal
// R3 - Codes 0101, 0100 select low-frequency crystal
// R4 - Code 0011 selects 128 kHz RC
// R5 - Code 0010 selects calibrated RC
// R6 - Fuse one unprogrammed, zero programmed
// R7 - Default: calibrated RC divided by eight
// R8 - Default start-up bits are 10
// R9 - Watchdog-timed time-out after other resets release
// R10 - Time-out is 0, 512 or 8192 cycles
// R11 - Oscillator cycle counter holds reset, then releases
// R12 - Wake applies only start-up count
// R13 - Low-power range codes chosen by frequency
// R14 - Range code 100 only for resonators
// R15 - Divide fuse programmed divides clock by eight
// R16 - Low bit with start-up bits picks timing
// R17 - 0/00: 258 cycles, 14 plus 4.1 ms
// R18 - Slow power resonator: 14 plus 65 ms
// R19 - 0/10 no time-out, 0/11 adds 4.1 ms
// R20 - 1/01: 16K cycles, 14 cycles only
// R21 - 1/10: 16K cycles, plus 4.1 ms
// R22 - 1/11: 16K cycles, plus 65 ms
// R23 - Zero code external clock, 0001 reserved
// R24 - Reassertion restarts both counters from zero
`timescale 1ns/100ps
`default_nettype none
`include "clk_startup_map.svh"

module clock_source_startup_control
#(
	parameter int TIMEOUT_WIDTH = 14,
	parameter int STARTUP_WIDTH = 16
)
(
	// Clock and reset
	input  wire logic                           core_clk,
	input  wire logic                           sys_rst,
	// Configuration fuses
	input  wire logic [3:0]                     clock_source_select,
	input  wire logic [1:0]                     startup_time_select,
	input  wire logic                           clock_divide_by_eight_fuse,
	// Reset sources and wake request
	input  wire logic                           external_reset_active,
	input  wire logic                           wake_request,
	// Oscillator and watchdog ticks, one cycle pulses
	input  wire logic                           watchdog_tick,
	input  wire logic                           oscillator_tick,
	// Status
	output clk_startup_pkg::clock_source_t      selected_source,
	output logic                                internal_reset,
	output logic                                system_clock_enable,
	output logic                                fuse_reserved,
	output logic                                waking
);

	// ==========================================================
	// Elaboration checks
	if (TIMEOUT_WIDTH < 14 || STARTUP_WIDTH < 16)
	begin : g_width_check
		$error("counter widths too small for the longest delays");
	end

	// ==========================================================
	// State
	typedef struct packed {
		clk_startup_pkg::fuse_set_t     fuses;
		clk_startup_pkg::clock_source_t source;
		clk_startup_pkg::startup_plan_t plan;
		clk_startup_pkg::phase_t        phase;
		logic [TIMEOUT_WIDTH-1:0]       tout_count;
		logic [STARTUP_WIDTH-1:0]       su_count;
		logic [2:0]                     div_count;
		logic                           clock_enable;
		logic                           from_wake;
		logic                           hold_reset;
		logic                           wake_startup;
	} state_t;

	// Factory default: calibrated RC, longest start-up, divider fuse programmed
	localparam state_t RESET_STATE = '{
		fuses:        '{`RST_CLOCK_SOURCE, `RST_STARTUP_TIME, `RST_DIVIDE_FUSE},
		source:       clk_startup_pkg::SRC_RC_CALIBRATED,
		plan:         '{`TOUT_LONG, `SU_6CK, 1'b0},
		phase:        clk_startup_pkg::PH_HOLD,
		tout_count:   '0,
		su_count:     '0,
		div_count:    3'h0,
		clock_enable: 1'b0,
		from_wake:    1'b0,
		hold_reset:   1'b1,
		wake_startup: 1'b0
	};

	state_t state;
	state_t next_state;

	clk_startup_pkg::fuse_set_t     fuse_in;
	clk_startup_pkg::clock_source_t dec_source;
	clk_startup_pkg::startup_plan_t dec_plan;

	assign fuse_in = '{clock_source_select:        clock_source_select,
	                   startup_time_select:        startup_time_select,
	                   clock_divide_by_eight_fuse: clock_divide_by_eight_fuse};

	clock_startup_decode u_decode
	(
		.fuses  (fuse_in),
		.source (dec_source),
		.plan   (dec_plan)
	);

	// ==========================================================
	// Next state
	always_comb
	begin
		next_state = state;
		next_state.clock_enable = 1'b0;
		unique case (state.phase)
			clk_startup_pkg::PH_HOLD:
			begin
				// Fuses are latched while reset is held so a change mid-sequence has no effect
				next_state.fuses      = fuse_in;
				next_state.source     = dec_source;
				next_state.plan       = dec_plan;
				next_state.tout_count = '0;
				next_state.su_count   = '0;
				next_state.from_wake  = 1'b0;
				if (!external_reset_active && !dec_plan.reserved_code)
					next_state.phase = clk_startup_pkg::PH_TIMEOUT; // see R9
			end
			clk_startup_pkg::PH_TIMEOUT:
			begin
				if (TIMEOUT_WIDTH'(state.plan.timeout_cycles) == state.tout_count) // see R10
					next_state.phase = clk_startup_pkg::PH_STARTUP;
				else if (watchdog_tick)
					next_state.tout_count = state.tout_count + 1'b1; // see R9
			end
			clk_startup_pkg::PH_STARTUP:
			begin
				// The fixed 14-cycle extension rides on the start-up count after a reset only
				if (state.su_count == STARTUP_WIDTH'(state.plan.startup_cycles)
					+ (state.from_wake ? STARTUP_WIDTH'(0) : STARTUP_WIDTH'(`SU_EXTRA_CK))) // see R12
					next_state.phase = clk_startup_pkg::PH_RUN; // see R11
				else if (oscillator_tick)
					next_state.su_count = state.su_count + 1'b1; // see R11
			end
			clk_startup_pkg::PH_RUN:
			begin
				next_state.div_count = state.div_count + 1'b1;
				// Programmed (zero) fuse means divide by eight
				next_state.clock_enable = state.fuses.clock_divide_by_eight_fuse
					|| state.div_count == 3'(`DIVIDE_RATIO - 1); // see R15, R6
				if (wake_request)
				begin
					// Wake from power-save or power-down skips the time-out
					next_state.phase     = clk_startup_pkg::PH_STARTUP; // see R12
					next_state.su_count  = '0;
					next_state.from_wake = 1'b1;
					next_state.div_count = '0;
				end
			end
		endcase
		if (external_reset_active)
		begin
			next_state.phase      = clk_startup_pkg::PH_HOLD; // see R24
			next_state.tout_count = '0;
			next_state.su_count   = '0;
		end
		// Reset and wake status leave from flip-flops: decoding the phase outside would glitch
		next_state.hold_reset   = next_state.phase != clk_startup_pkg::PH_RUN; // see R11
		next_state.wake_startup = next_state.from_wake
			&& next_state.phase == clk_startup_pkg::PH_STARTUP; // see R12
	end

	// ==========================================================
	// Registers
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			state <= RESET_STATE; // see R7, R8
		else
			state <= next_state;
	end

	// ==========================================================
	// Outputs
	assign selected_source     = state.source;
	assign internal_reset      = state.hold_reset;
	assign system_clock_enable = state.clock_enable;
	assign fuse_reserved       = state.plan.reserved_code;
	assign waking              = state.wake_startup;

endmodule // clock_source_startup_control

`default_nettype wire

// >>> hw/clock_startup_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "clk_startup_map.svh"

module clock_startup_decode
(
	// Fuse inputs
	input  wire clk_startup_pkg::fuse_set_t    fuses,
	// Decoded selection
	output clk_startup_pkg::clock_source_t     source,
	output clk_startup_pkg::startup_plan_t     plan
);

	logic [3:0] sel;
	logic [1:0] sut;
	logic       low_bit;

	assign sel     = fuses.clock_source_select;
	assign sut     = fuses.startup_time_select;
	assign low_bit = sel[0];

	always_comb
	begin
		source = clk_startup_pkg::SRC_NONE;
		plan   = '{timeout_cycles: `TOUT_NONE, startup_cycles: `SU_6CK, reserved_code: 1'b0};
		// Crystal and resonator sources: the low select bit and start-up bits pick the pair
		if (sel[3] || sel[3:1] == `CSS_FULL_SWING_MSB)
		begin
			if (sel[3])
				source = clk_startup_pkg::SRC_LOW_POWER_XTAL; // see R1
			else
				source = clk_startup_pkg::SRC_FULL_SWING_XTAL; // see R2
			unique case ({low_bit, sut}) // see R16
				3'h0:
				begin
					plan.startup_cycles = `SU_258CK; // see R17
					plan.timeout_cycles = `TOUT_SHORT;
				end
				3'h1:
				begin
					plan.startup_cycles = `SU_258CK; // see R18
					plan.timeout_cycles = `TOUT_LONG;
				end
				3'h2:
				begin
					plan.startup_cycles = `SU_1KCK; // see R19
					plan.timeout_cycles = `TOUT_NONE;
				end
				3'h3:
				begin
					plan.startup_cycles = `SU_1KCK; // see R19
					plan.timeout_cycles = `TOUT_SHORT;
				end
				3'h4:
				begin
					plan.startup_cycles = `SU_1KCK; // see R18
					plan.timeout_cycles = `TOUT_LONG;
				end
				3'h5:
				begin
					plan.startup_cycles = `SU_16KCK; // see R20
					plan.timeout_cycles = `TOUT_NONE;
				end
				3'h6:
				begin
					plan.startup_cycles = `SU_16KCK; // see R21
					plan.timeout_cycles = `TOUT_SHORT;
				end
				3'h7:
				begin
					plan.startup_cycles = `SU_16KCK; // see R22
					plan.timeout_cycles = `TOUT_LONG;
				end
			endcase
		end
		else if (sel[3:1] == `CSS_LOW_FREQ_MSB)
		begin
			source = clk_startup_pkg::SRC_LOW_FREQ_XTAL; // see R3
			plan.startup_cycles = low_bit ? `SU_32KCK : `SU_1KCK;
			unique case (sut)
				2'h0: plan.timeout_cycles = `TOUT_NONE;
				2'h1: plan.timeout_cycles = `TOUT_SHORT;
				2'h2: plan.timeout_cycles = `TOUT_LONG;
				2'h3:
				begin
					// Reserved combination: no clock is offered
					source = clk_startup_pkg::SRC_NONE;
					plan.reserved_code = 1'b1;
				end
			endcase
		end
		else
		begin
			// Simple sources start after a short count; time-out still follows the start-up bits
			unique case (sut)
				2'h0: plan.timeout_cycles = `TOUT_NONE;
				2'h1: plan.timeout_cycles = `TOUT_SHORT;
				2'h2: plan.timeout_cycles = `TOUT_LONG;
				2'h3: plan.reserved_code = 1'b1;
			endcase
			unique case (sel)
				`CSS_RC_128K:       source = clk_startup_pkg::SRC_RC_128K; // see R4
				`CSS_RC_CALIBRATED: source = clk_startup_pkg::SRC_RC_CALIBRATED; // see R5
				`CSS_EXTERNAL:      source = clk_startup_pkg::SRC_EXTERNAL; // see R23
				default:
				begin
					source = clk_startup_pkg::SRC_NONE; // see R23
					plan.reserved_code = 1'b1;
				end
			endcase
			if (plan.reserved_code)
				source = clk_startup_pkg::SRC_NONE;
		end
	end

endmodule // clock_startup_decode

`default_nettype wire

// >>> shared/clk_startup_map.svh
`ifndef CLK_STARTUP_MAP_SVH
`define CLK_STARTUP_MAP_SVH

// Clock source select codes
`define CSS_EXTERNAL        4'h0
`define CSS_RESERVED        4'h1
`define CSS_RC_CALIBRATED   4'h2
`define CSS_RC_128K         4'h3
`define CSS_LOW_FREQ_MSB    3'h2
`define CSS_FULL_SWING_MSB  3'h3

// Factory default fuse values (zero means programmed)
`define RST_CLOCK_SOURCE    4'h2
`define RST_STARTUP_TIME    2'h2
`define RST_DIVIDE_FUSE     1'h0

// Watchdog cycle counts of the reset time-out delay
`define TOUT_NONE           14'h0000
`define TOUT_SHORT          14'h0200
`define TOUT_LONG           14'h2000

// Oscillator start-up counts, plus the fixed reset extension
`define SU_EXTRA_CK         16'h000E
`define SU_6CK              16'h0006
`define SU_258CK            16'h0102
`define SU_1KCK             16'h0400
`define SU_16KCK            16'h4000
`define SU_32KCK            16'h8000

`define DIVIDE_RATIO        4'h8

`endif

// >>> shared/clk_startup_pkg.sv
`default_nettype none
package clk_startup_pkg;

	typedef enum logic [2:0] {
		SRC_NONE,
		SRC_EXTERNAL,
		SRC_RC_CALIBRATED,
		SRC_RC_128K,
		SRC_LOW_FREQ_XTAL,
		SRC_FULL_SWING_XTAL,
		SRC_LOW_POWER_XTAL
	} clock_source_t;

	typedef struct packed {
		logic [3:0] clock_source_select;
		logic [1:0] startup_time_select;
		logic       clock_divide_by_eight_fuse;
	} fuse_set_t;

	typedef struct packed {
		logic [13:0] timeout_cycles;
		logic [15:0] startup_cycles;
		logic        reserved_code;
	} startup_plan_t;

	typedef enum logic [1:0] {
		PH_HOLD,
		PH_TIMEOUT,
		PH_STARTUP,
		PH_RUN
	} phase_t;

endpackage

`default_nettype wire
